// file: cpdc_partner.sv
// Clock source and reference model at the far side of the block
`timescale 1ns/10ps
`default_nettype none
module cpdc_partner (
	output var logic       crystal_in,
	output var logic [2:0] rate_ref_in
);
	// Crystal runs free, so it outlasts every power-down sequence
	initial begin
		crystal_in = 1'h0;
		forever #20.345 crystal_in = ~crystal_in;
	end
	// References are always driven, never left floating
	initial begin
		rate_ref_in = 3'h0;
		forever #250 rate_ref_in = rate_ref_in + 3'h1;
	end
endmodule
`default_nettype wire

// file: cpdc_pkg.sv
// Package of constants and types for the clock outputs and power-down control block
package cpdc_pkg;
	// Control word 28 bit positions (held as plain ports here)
	localparam int CPDC_R28_MCLK_DIS_BIT = 0;
	localparam int CPDC_R28_CONV_EN_LSB  = 1;
	localparam int CPDC_R28_BIT_EN_LSB   = 4;
	// Status word 0 init flag position
	localparam int CPDC_R0_INIT_BIT      = 15;
	// Mixer control word 8 mute bit positions
	localparam int CPDC_R8_MONO_IN_MUTE  = 15;
	localparam int CPDC_R8_MONO_OUT_MUTE = 6;
	// Reset values of the control bits
	localparam logic       CPDC_RST_MCLK_DIS = 1'h0;
	localparam logic [2:0] CPDC_RST_CONV_EN  = 3'h0;
	localparam logic [2:0] CPDC_RST_BIT_EN   = 3'h0;
	localparam logic       CPDC_RST_INIT     = 1'h0;
	// Timing: clock rate and sequence times
	localparam int CPDC_CLK_KHZ      = 40000;
	localparam int CPDC_PDN_US       = 5000;
	localparam int CPDC_PUP_US       = 470000;
	localparam int CPDC_CAL_US       = 4000;
	localparam int CPDC_PDN_CYC      = CPDC_PDN_US * (CPDC_CLK_KHZ / 1000);
	localparam int CPDC_PUP_CYC      = CPDC_PUP_US * (CPDC_CLK_KHZ / 1000);
	localparam int CPDC_CAL_CYC      = CPDC_CAL_US * (CPDC_CLK_KHZ / 1000);
	localparam int CPDC_CONV_RATIO   = 128;
	localparam int CPDC_XTAL_MIN_RATIO = 512;
	// Power sequencer states
	typedef enum logic [4:0] {
		CPDC_OFF  = 5'h01,
		CPDC_PUP  = 5'h02,
		CPDC_CAL  = 5'h04,
		CPDC_ON   = 5'h08,
		CPDC_PDN  = 5'h10
	} cpdc_state_t;
endpackage

// file: cpdc_rate_gen.sv
// Rate clock generator: fractional accumulator toggling an output
`timescale 1ns/10ps
`default_nettype none
module cpdc_rate_gen #(
	parameter int ACC_W = 24
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [ACC_W-1:0] step,
	output logic                  clk_out
);
	if (ACC_W < 4) begin : g_bad_width
		$error("cpdc_rate_gen: ACC_W too small");
	end

	logic [ACC_W:0] acc;

	// Accumulator wraps give the average half period; jitter of one cycle is traded for range
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc     <= '0;
			clk_out <= 1'h0;
		end else if (!run) begin
			acc     <= '0;
			clk_out <= 1'h0;
		end else begin
			acc <= {1'b0, acc[ACC_W-1:0]} + {1'b0, step};
			if (acc[ACC_W])
				clk_out <= ~clk_out;
		end
	end
endmodule
`default_nettype wire

// file: cpdc_sva.sv
// Checker of the clock output and power-down control ports
`timescale 1ns/10ps
`default_nettype none
module cpdc_sva #(
	parameter int PDN_CYC = 20
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       quiet_shutdown_n,
	input wire logic       mclk_disable,
	input wire logic [2:0] conv_enable,
	input wire logic [2:0] bit_enable,
	input wire logic       mixer_down,
	input wire logic       mono_in_mute,
	input wire logic       mono_out_mute,
	input wire logic       mono_bypass_enable,
	input wire logic       master_clock_oe,
	input wire logic [2:0] conversion_clock_oe,
	input wire logic [2:0] bit_clock_oe,
	input wire logic       init_done,
	input wire logic       powered_up,
	input wire logic       mono_to_mono_out,
	input wire logic       mono_to_first_line_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int low_cnt;
	// Cycles without power, saturating so a long idle never wraps
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			low_cnt <= 0;
		else if (powered_up)
			low_cnt <= 0;
		else if (low_cnt < PDN_CYC)
			low_cnt <= low_cnt + 1;
	end
	conv_drive_a: assert property ((conversion_clock_oe & ~$past(conv_enable)) == 3'h0)
		else $error("conversion clock driven while disabled");
	bit_drive_a: assert property ((bit_clock_oe & ~$past(bit_enable)) == 3'h0)
		else $error("bit clock driven while disabled");
	// Disable bit bites in PUP, CAL and ON without shutdown and is checked while powered up; restored defaults keep the pin driven
	mclk_off_a: assert property ($past(mclk_disable) && powered_up |-> !master_clock_oe)
		else $error("master clock driven while disabled");
	mclk_default_a: assert property (!$past(mclk_disable) |-> master_clock_oe)
		else $error("master clock not driven by default");
	pdn_time_a: assert property ($rose(init_done) |-> low_cnt >= PDN_CYC - 2)
		else $error("power-down finished early");
	shut_sync_a: assert property ($fell(quiet_shutdown_n) && powered_up
		|=> powered_up ##[1:4] !powered_up) else $error("shutdown timing wrong");
	bypass_a: assert property ($past(mixer_down) |-> mono_to_mono_out == $past(mono_bypass_enable))
		else $error("bypass path wrong");
	mono_up_a: assert property (!$past(mixer_down)
		|-> mono_to_mono_out == !($past(mono_in_mute) || $past(mono_out_mute)))
		else $error("mono path wrong");
	line_one_a: assert property (mono_to_first_line_out
		== (!$past(mixer_down) && !$past(mono_in_mute))) else $error("line path wrong");
	cover property ($rose(powered_up));
	cover property ($rose(init_done));
	cover property (mixer_down && mono_to_mono_out);
endmodule
`default_nettype wire

// file: cpdc_top.sv
// Clock outputs and power-down control block
`timescale 1ns/10ps
`default_nettype none
module cpdc_top
	import cpdc_pkg::*;
#(
	parameter int PDN_CYC = CPDC_PDN_CYC,
	parameter int PUP_CYC = CPDC_PUP_CYC,
	parameter int CAL_CYC = CPDC_CAL_CYC,
	parameter int ACC_W   = 24
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             crystal_in,
	input  wire logic             quiet_shutdown_n,
	input  wire logic             power_up_req,
	input  wire logic             mclk_disable,
	input  wire logic [2:0]       conv_enable,
	input  wire logic [2:0]       bit_enable,
	input  wire logic [2:0]       conv_x128,
	input  wire logic [2:0]       rate_direct,
	input  wire logic [2:0]       rate_ref_in,
	input  wire logic [3*ACC_W-1:0] conv_step,
	input  wire logic [3*ACC_W-1:0] bit_step,
	input  wire logic             mixer_down,
	input  wire logic             mono_in_mute,
	input  wire logic             mono_out_mute,
	input  wire logic             mono_bypass_enable,
	output logic                  master_clock_out,
	output logic                  master_clock_oe,
	output logic [2:0]            conversion_clock_out,
	output logic [2:0]            conversion_clock_oe,
	output logic [2:0]            bit_clock_out,
	output logic [2:0]            bit_clock_oe,
	output logic [2:0]            pll_ref_clk,
	output logic                  init_done,
	output logic                  powered_up,
	output logic                  mono_to_mono_out,
	output logic                  mono_to_first_line_out
);
	if (PDN_CYC < 1 || PUP_CYC < 1 || CAL_CYC < 1) begin : g_bad_cyc
		$error("cpdc_top: bad cycle counts");
	end
	if (ACC_W < 4) begin : g_bad_width
		$error("cpdc_top: ACC_W too small");
	end

	cpdc_state_t state;
	cpdc_state_t next_state;
	logic [31:0] cnt;
	logic [1:0]  shdn_sync;
	logic [1:0]  xtal_sync;
	logic [2:0]  ref_s1;
	logic [2:0]  ref_s2;
	logic        shdn_req;
	logic        cnt_done;
	logic [2:0]  conv_raw;
	logic [2:0]  conv_div;
	logic [2:0]  bit_raw;
	logic        ctl_clear;

	function automatic logic cycles_done(input logic [31:0] c, input int lim);
		return c >= 32'(lim - 1);
	endfunction

	// Shutdown pin passes two flops; reset itself is applied without the clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			shdn_sync <= 2'h3;
		else
			shdn_sync <= {shdn_sync[0], quiet_shutdown_n};
	end
	assign shdn_req = ~shdn_sync[1];

	// Crystal level sampled twice; its edges are re-timed onto ref_clk, with no duty correction
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			xtal_sync <= 2'h0;
		else
			xtal_sync <= {xtal_sync[0], crystal_in};
	end

	// Master clock copy, enabled after reset until the disable bit is set in PUP, CAL or ON without shutdown
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			master_clock_out <= 1'h0;
			master_clock_oe  <= ~CPDC_RST_MCLK_DIS;
		end else begin
			master_clock_out <= xtal_sync[1];
			// Restored defaults leave the pin driven, so shutdown never floats it
			master_clock_oe  <= ctl_clear ? ~CPDC_RST_MCLK_DIS : ~mclk_disable;
		end
	end

	// Sequencer: opposite request waits until the running sequence ends
	assign cnt_done = (state == CPDC_PUP) ? cycles_done(cnt, PUP_CYC) :
	                  (state == CPDC_CAL) ? cycles_done(cnt, CAL_CYC) :
	                  cycles_done(cnt, PDN_CYC);
	always_comb begin
		next_state = state;
		case (state)
			CPDC_OFF: if (power_up_req && !shdn_req) next_state = CPDC_PUP;
			CPDC_PUP: if (cnt_done) next_state = CPDC_CAL;
			CPDC_CAL: if (cnt_done) next_state = shdn_req ? CPDC_PDN : CPDC_ON;
			CPDC_ON:  if (shdn_req) next_state = CPDC_PDN;
			CPDC_PDN: if (cnt_done) next_state = CPDC_OFF;
			default:  next_state = CPDC_OFF;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			state <= CPDC_OFF;
		else
			state <= next_state;
	end

	// Phase counter restarts on each state change
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt <= 32'h0;
		else if (next_state != state)
			cnt <= 32'h0;
		else
			cnt <= cnt + 32'h1;
	end

	// Init flag: set when power-down ends, cleared when power-up starts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			init_done  <= CPDC_RST_INIT;
			powered_up <= 1'h0;
		end else begin
			if (state == CPDC_PDN && next_state == CPDC_OFF)
				init_done <= 1'h1;
			else if (state == CPDC_OFF && next_state == CPDC_PUP)
				init_done <= 1'h0;
			powered_up <= (next_state == CPDC_ON);
		end
	end

	// Shutdown forces control outputs back to their defaults
	assign ctl_clear = shdn_req || state == CPDC_PDN || state == CPDC_OFF;

	// Reference inputs synchronised, then gated off where rate is direct
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ref_s1      <= 3'h0;
			ref_s2      <= 3'h0;
			pll_ref_clk <= 3'h0;
		end else begin
			ref_s1      <= rate_ref_in;
			ref_s2      <= ref_s1;
			pll_ref_clk <= ref_s2 & ~rate_direct;
		end
	end

	// Per channel: bit clock, conversion clock at 128x or divided down by 128
	for (genvar i = 0; i < 3; i++) begin : g_ch
		logic       raw_q;
		logic [5:0] edge_cnt;
		logic       div;
		cpdc_rate_gen #(.ACC_W(ACC_W)) u_conv (
			.ref_clk (ref_clk),
			.rst     (rst),
			.run     (powered_up),
			.step    (conv_step[i*ACC_W +: ACC_W]),
			.clk_out (conv_raw[i])
		);
		cpdc_rate_gen #(.ACC_W(ACC_W)) u_bit (
			.ref_clk (ref_clk),
			.rst     (rst),
			.run     (powered_up),
			.step    (bit_step[i*ACC_W +: ACC_W]),
			.clk_out (bit_raw[i])
		);
		// Divide by 128: one toggle every 64 rising edges of the fast clock
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				raw_q    <= 1'h0;
				edge_cnt <= 6'h0;
				div      <= 1'h0;
			end else begin
				raw_q <= conv_raw[i];
				if (conv_raw[i] && !raw_q) begin
					if (edge_cnt == 6'(CPDC_CONV_RATIO / 2 - 1)) begin
						edge_cnt <= 6'h0;
						div      <= ~div;
					end else begin
						edge_cnt <= edge_cnt + 6'h1;
					end
				end
			end
		end
		assign conv_div[i] = div;
	end

	// Rate pins: driven only when enabled; default is tristate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conversion_clock_out <= 3'h0;
			conversion_clock_oe  <= CPDC_RST_CONV_EN;
			bit_clock_out        <= 3'h0;
			bit_clock_oe         <= CPDC_RST_BIT_EN;
		end else begin
			conversion_clock_out <= (conv_x128 & conv_raw) | (~conv_x128 & conv_div);
			conversion_clock_oe  <= conv_enable & {3{~ctl_clear}};
			bit_clock_out        <= bit_raw;
			bit_clock_oe         <= bit_enable & {3{~ctl_clear}};
		end
	end

	// Mono feedthrough routing; bypass pin is assumed stable in total power-down
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mono_to_mono_out       <= 1'h0;
			mono_to_first_line_out <= 1'h0;
		end else if (mixer_down) begin
			mono_to_mono_out       <= mono_bypass_enable;
			mono_to_first_line_out <= 1'h0;
		end else begin
			mono_to_mono_out       <= ~mono_in_mute & ~mono_out_mute;
			mono_to_first_line_out <= ~mono_in_mute;
		end
	end
endmodule
`default_nettype wire

// file: test_clock_outputs_and_power_down_control.sv
// Testbench of the clock output and power-down control block
`timescale 1ns/10ps
`default_nettype none
module test_clock_outputs_and_power_down_control;
	localparam int PDN = 20;
	localparam int PUP = 50;
	localparam int CAL = 10;
	logic        ref_clk, rst, xtal, qs_n, pur, mdis, md, im, om, byp, up;
	logic        mco, moe, ipd, pup, mm, ml;
	logic [2:0]  cen, ben, x128, rdir, rref, co, coe, bo, boe, pll;
	logic [71:0] step;
	int          miscompares, total_checks, n, t [4];
	cpdc_top #(.PDN_CYC(PDN), .PUP_CYC(PUP), .CAL_CYC(CAL)) cpdc_top_i (
		.ref_clk(ref_clk), .rst(rst), .crystal_in(xtal), .quiet_shutdown_n(qs_n),
		.power_up_req(pur), .mclk_disable(mdis), .conv_enable(cen), .bit_enable(ben),
		.conv_x128(x128), .rate_direct(rdir), .rate_ref_in(rref), .conv_step(step),
		.bit_step(step), .mixer_down(md), .mono_in_mute(im), .mono_out_mute(om),
		.mono_bypass_enable(byp), .master_clock_out(mco), .master_clock_oe(moe),
		.conversion_clock_out(co), .conversion_clock_oe(coe), .bit_clock_out(bo),
		.bit_clock_oe(boe), .pll_ref_clk(pll), .init_done(ipd), .powered_up(pup),
		.mono_to_mono_out(mm), .mono_to_first_line_out(ml));
	cpdc_partner cpdc_partner_i (.crystal_in(xtal), .rate_ref_in(rref));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// Bounded wait; n keeps the cycles taken, up notes any power-up seen
	task automatic wait_hi(ref logic f, input int lim);
		n = 0;
		while (f !== 1'h1 && n < lim) begin
			cyc(1);
			up = up | pup;
			n++;
		end
	endtask
	// Toggle counts of master, conversion, bit and reference clocks
	task automatic watch(input int k);
		logic [3:0] last;
		logic [3:0] cur;
		t = '{0, 0, 0, 0};
		last = {pll[0], bo[0], co[0], mco};
		repeat (k) begin
			cyc(1);
			cur = {pll[0], bo[0], co[0], mco};
			for (int j = 0; j < 4; j++)
				if (cur[j] !== last[j])
					t[j]++;
			last = cur;
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard, well beyond the five thousand or so cycles the run needs
	initial begin
		#(25 * 20000);
		miscompares++;
		finish_test;
	end
	initial begin
		{rst, qs_n, pur, mdis, md, im, om, byp, up} = 9'h188;
		{cen, ben, x128, rdir} = 12'h0;
		step = {3{24'h100000}};
		miscompares = 0;
		total_checks = 0;
		repeat (16) @(posedge ref_clk);
		#1 rst = 1'h0;
		cyc(1);
		check({moe, coe, boe, ipd, pup}, 9'h100);
		{cen, ben, x128} = 9'h1ff;
		pur = 1'h1;
		cyc(1);
		pur = 1'h0;
		wait_hi(pup, 200);
		check(n >= PUP + CAL && n < PUP + CAL + 5, 1);
		check({moe, coe, boe}, 7'h7f);
		// Skip the accumulators' first fill so the window holds whole periods
		cyc(9);
		watch(128);
		check({t[0] > 0, t[3] > 0}, 2'h3);
		check(t[1], 8);
		check(t[2], 8);
		rdir = 3'h7;
		x128 = 3'h0;
		cyc(4);
		// Two half periods of the clock slowed by 128 fit in 4096 cycles
		watch(4096);
		check(t[3], 0);
		check(t[1], 2);
		mdis = 1'h1;
		cen = 3'h2;
		cyc(2);
		check({moe, coe}, 4'h2);
		// Bypass level moves only while the mixer is up
		for (int i = 0; i < 16; i++) begin
			if (byp !== i[3]) begin
				md = 1'h0;
				cyc(1);
			end
			{byp, md, im, om} = i[3:0];
			cyc(2);
			check({mm, ml}, {md ? byp : !im && !om, !md && !im});
		end
		md = 1'h0;
		cyc(1);
		{byp, md, im, om} = 4'h2;
		qs_n = 1'h0;
		wait_hi(ipd, 200);
		check(n >= PDN && n < PDN + 8, 1);
		check({moe, coe, boe, pup}, 8'h80);
		qs_n = 1'h1;
		pur = 1'h1;
		cyc(4);
		pur = 1'h0;
		check(ipd, 0);
		qs_n = 1'h0;
		up = 1'h0;
		wait_hi(ipd, 400);
		check({up, n >= PUP + CAL + PDN - 10}, 2'h1);
		qs_n = 1'h1;
		pur = 1'h1;
		wait_hi(pup, 200);
		pur = 1'h0;
		rst = 1'h1;
		#1 check({moe, pup}, 2'h2);
		cyc(2);
		rst = 1'h0;
		cyc(2);
		check({ipd, pup, coe}, 5'h0);
		finish_test;
	end
endmodule
bind cpdc_top cpdc_sva #(.PDN_CYC(PDN_CYC)) cpdc_sva_i (.ref_clk, .rst, .quiet_shutdown_n,
	.mclk_disable, .conv_enable, .bit_enable, .mixer_down, .mono_in_mute, .mono_out_mute,
	.mono_bypass_enable, .master_clock_oe, .conversion_clock_oe, .bit_clock_oe, .init_done,
	.powered_up, .mono_to_mono_out, .mono_to_first_line_out);
`default_nettype wire
